/* src/mcps_top.v */
// Purpose: Power-state sequencer between a compute module and its carrier.
// Assumes: ref_clk at 20 MHz, rst synchronous active high, pins asynchronous.
// Notes: Registers on Avalon-MM with one wait state on every access.
`timescale 1ns/1ps
`include "mcps_defines.vh"
`default_nettype none
module mcps_top #(
    parameter NWAKE = 4,
    parameter SEQ_CYC = `MCPS_SEQ_CYC,
    parameter STRAP_WIDE = 1'b1
) (
    input wire ref_clk, // 20 MHz clock.
    input wire rst, // Synchronous reset, active high.
    input wire [3:0] avs_address, // Byte address.
    input wire avs_read, // Read strobe.
    input wire avs_write, // Write strobe.
    input wire [31:0] avs_writedata, // Write data.
    input wire [3:0] avs_byteenable, // Byte enables.
    output reg [31:0] avs_readdata, // Read data.
    output wire avs_waitrequest, // Wait request.
    input wire power_en, // Power-on / power-good pin.
    input wire module_reset_n_in, // Module reset pin level.
    output wire module_reset_n_out, // Module reset drive value, always 0.
    output wire module_reset_n_oe, // Module reset pull-down enable.
    output wire shutdown_req_n_out, // Shutdown request drive value, always 0.
    output wire shutdown_req_n_oe, // Shutdown request pull-down enable.
    output reg module_sleep_indicator_n, // Low in deep sleep.
    output wire supply_range_strap_out, // Strap drive value, always 0.
    output wire supply_range_strap_oe, // Strap pull-down enable (legacy).
    input wire vdd_in_ok, // Main input power present.
    input wire temp_unsafe, // Thermal shutdown level.
    input wire temp_limit, // Hot or cold limit crossed.
    input wire undervoltage, // Under-voltage event level.
    input wire usb_vbus, // USB bus power present.
    input wire [NWAKE-1:0] wake_pins, // Connector wake signals.
    output wire [2:0] power_state // One-hot off, on, sleep.
);
    localparam [2:0] ST_OFF = 3'b001;
    localparam [2:0] ST_ON = 3'b010;
    localparam [2:0] ST_SLEEP = 3'b100;
    localparam HW_CYC = `MCPS_HWOFF_CYC;

    reg [2:0] state_q;
    reg [31:0] ctrl_q;
    reg [31:0] wake_q;
    reg shdn_req_q;
    reg rst_rel_q;
    reg [7:0] seq_cnt_q;
    reg pe_prev_q;
    reg ack_q;
    wire pe_s;
    wire mrst_s;
    wire pe_low_ok;
    wire sw_shdn = ctrl_q[`MCPS_CTRL_SW_SHDN];
    wire sw_sleep = ctrl_q[`MCPS_CTRL_SLEEP];
    wire sw_run = ctrl_q[`MCPS_CTRL_SW_RUN];
    wire usb_wake = wake_q[`MCPS_WAKE_USB_EN] & usb_vbus;
    wire pin_wake = |(wake_q[`MCPS_WAKE_PIN_LSB +: NWAKE] & wake_pins);
    wire pe_rise = pe_s & ~pe_prev_q;
    wire req_ev = temp_unsafe | undervoltage | (sw_shdn & sw_run & (state_q == ST_ON));

    mcps_sync #(.RST_VAL(1'b0)) u_pe_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .d(power_en),
        .q(pe_s)
    );

    mcps_sync #(.RST_VAL(1'b0)) u_rst_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .d(module_reset_n_in),
        .q(mrst_s)
    );

    mcps_lowtimer #(.CYCLES(HW_CYC), .W(16)) u_pe_low (
        .ref_clk(ref_clk),
        .rst(rst),
        .level(pe_s),
        .low_ok(pe_low_ok)
    );

    // Power-state machine.
    always @(posedge ref_clk) begin
        if (rst) begin
            state_q <= ST_OFF;
            pe_prev_q <= 1'b0;
            shdn_req_q <= 1'b0;
            rst_rel_q <= 1'b0;
            seq_cnt_q <= 8'h00;
        end else begin
            pe_prev_q <= pe_s;
            case (state_q)
                ST_OFF: begin
                    shdn_req_q <= 1'b0;
                    rst_rel_q <= 1'b0;
                    seq_cnt_q <= 8'h00;
                    if (pe_rise && vdd_in_ok && !temp_unsafe) begin
                        state_q <= ST_ON;
                    end
                end
                ST_ON: begin
                    // Internal sequence runs before the reset release.
                    if (!rst_rel_q && pe_s) begin
                        if (seq_cnt_q == SEQ_CYC[7:0] - 8'h01) begin
                            rst_rel_q <= 1'b1;
                        end else begin
                            seq_cnt_q <= seq_cnt_q + 8'h01;
                        end
                    end
                    if (req_ev) begin
                        shdn_req_q <= 1'b1;
                    end
                    // Supplies stay up until the carrier drops power-on.
                    if (pe_low_ok) begin
                        rst_rel_q <= 1'b0;
                        state_q <= ST_OFF;
                    end else if (sw_sleep && sw_run && !req_ev && !shdn_req_q && rst_rel_q) begin
                        state_q <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    // Pins other than the sleep indicator keep their pre-sleep levels, except the shutdown request, set here on temp_unsafe.
                    if (temp_unsafe) begin
                        shdn_req_q <= 1'b1;
                    end
                    if (temp_limit || temp_unsafe || usb_wake || pin_wake || !pe_s) begin
                        state_q <= ST_ON;
                    end
                end
                default: begin
                    state_q <= ST_OFF;
                end
            endcase
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            module_sleep_indicator_n <= 1'b1;
        end else begin
            module_sleep_indicator_n <= (state_q != ST_SLEEP);
        end
    end

    assign power_state = state_q;
    assign module_reset_n_out = 1'b0;
    assign module_reset_n_oe = ~rst_rel_q;
    assign shutdown_req_n_out = 1'b0;
    assign shutdown_req_n_oe = shdn_req_q;
    assign supply_range_strap_out = 1'b0;
    assign supply_range_strap_oe = ~STRAP_WIDE;

    // Register bus: one wait state on every access.
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] be;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    always @(posedge ref_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
            ctrl_q <= `MCPS_CTRL_RST;
            wake_q <= `MCPS_WAKE_RST;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
            if (state_q == ST_OFF) begin
                ctrl_q <= `MCPS_CTRL_RST;
            end else if (avs_write && !ack_q && avs_address == `MCPS_REG_CTRL) begin
                ctrl_q <= merge(ctrl_q, avs_writedata, avs_byteenable) & 32'h0000_0007;
            end
            if (avs_write && !ack_q && avs_address == `MCPS_REG_WAKE) begin
                wake_q <= merge(wake_q, avs_writedata, avs_byteenable);
            end
            if (avs_read && !ack_q) begin
                case (avs_address)
                    `MCPS_REG_CTRL: avs_readdata <= ctrl_q;
                    `MCPS_REG_WAKE: avs_readdata <= wake_q;
                    `MCPS_REG_STAT: avs_readdata <= {22'h0, STRAP_WIDE, mrst_s, pe_s,
                        shdn_req_q, rst_rel_q, module_sleep_indicator_n, 1'b0, state_q};
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // mcps_top
`default_nettype wire

/* src/mcps_defines.vh */
// Purpose: Constants for the module/carrier power sequencer.
// Assumes: 20 MHz reference clock, byte addresses on Avalon-MM.
// Notes: Timing counts are derived from printed times.
`ifndef MCPS_DEFINES_VH
`define MCPS_DEFINES_VH

`define MCPS_CLK_HZ 20000000
`define MCPS_HWOFF_NS 10000
`define MCPS_HWOFF_CYC (((`MCPS_HWOFF_NS) * (`MCPS_CLK_HZ / 1000000) + 999) / 1000)
`define MCPS_SEQ_CYC 16

`define MCPS_REG_CTRL 4'h0
`define MCPS_REG_WAKE 4'h4
`define MCPS_REG_STAT 4'h8

`define MCPS_CTRL_SW_SHDN 0
`define MCPS_CTRL_SLEEP 1
`define MCPS_CTRL_SW_RUN 2
`define MCPS_WAKE_USB_EN 0
`define MCPS_WAKE_PIN_LSB 8
`define MCPS_CTRL_RST 32'h0000_0000
`define MCPS_WAKE_RST 32'h0000_0000

`endif

/* src/mcps_sync.v */
// Purpose: Two-stage synchroniser for one asynchronous level.
// Assumes: Single clock domain.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
`default_nettype none
module mcps_sync #(
    parameter RST_VAL = 1'b0
) (
    input wire ref_clk, // Clock.
    input wire rst, // Synchronous reset.
    input wire d, // Asynchronous input.
    output reg q // Synchronised output.
);
    reg meta_q;

    always @(posedge ref_clk) begin
        if (rst) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // mcps_sync
`default_nettype wire

/* src/mcps_lowtimer.v */
// Purpose: Qualifies a level held low for a minimum number of cycles.
// Assumes: Input already synchronised.
// Notes: Counter saturates so a long low gives a steady qualified level.
`timescale 1ns/1ps
`default_nettype none
module mcps_lowtimer #(
    parameter CYCLES = 200,
    parameter W = 16
) (
    input wire ref_clk, // Clock.
    input wire rst, // Synchronous reset.
    input wire level, // Monitored level.
    output reg low_ok // High once level was low long enough.
);
    localparam [W-1:0] LIM = CYCLES[W-1:0] - 1'b1;
    reg [W-1:0] cnt_q;

    always @(posedge ref_clk) begin
        if (rst || level) begin
            cnt_q <= {W{1'b0}};
            low_ok <= 1'b0;
        end else if (cnt_q != LIM) begin
            cnt_q <= cnt_q + 1'b1;
            low_ok <= 1'b0;
        end else begin
            low_ok <= 1'b1;
        end
    end
endmodule // mcps_lowtimer
`default_nettype wire

/* testbench/mcps_props.sv */
// Purpose: Port assertions for mcps_top.
// Assumes: One clock, rst synchronous.
// Notes: Bound below the module.
`timescale 1ns/1ps
`default_nettype none
module mcps_props #(
    parameter SEQ_CYC = 16
) (
    input wire logic ref_clk, // Clock.
    input wire logic rst, // Reset.
    input wire logic power_en, // Pin.
    input wire logic temp_unsafe, // Hot.
    input wire logic undervoltage, // Low rail.
    input wire logic module_reset_n_oe, // Reset pull.
    input wire logic shutdown_req_n_oe, // Request pull.
    input wire logic module_sleep_indicator_n, // Sleep flag.
    input wire logic [2:0] power_state // State.
);
    localparam int RB = SEQ_CYC + 8;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_one_hot: assert property ($onehot(power_state))
        else $error("state");
    a_on_from: assert property ($rose(power_state[1]) |-> $past(power_state[0] || power_state[2]))
        else $error("on entry");
    a_off_from: assert property ($rose(power_state[0]) |-> $past(power_state[1]) && !power_en)
        else $error("off entry");
    a_sleep_from: assert property ($rose(power_state[2]) |-> $past(power_state[1]))
        else $error("sleep entry");
    a_sleep_flag: assert property (power_state[2] && $past(power_state[2]) |-> !module_sleep_indicator_n)
        else $error("sleep flag");
    a_release_on: assert property ($fell(module_reset_n_oe) |-> power_state[1])
        else $error("release");
    a_release_time: assert property ($rose(power_state[1]) && $past(power_state[0]) |-> ##[1:RB] !module_reset_n_oe)
        else $error("release late");
    a_off_qual: assert property ($rose(power_state[0]) |-> !$past(power_en, 150))
        else $error("short low");
    a_event_req: assert property ((temp_unsafe || undervoltage) && power_state[1] |-> ##[0:2] shutdown_req_n_oe)
        else $error("no request");
    a_off_reset: assert property (power_state[0] && $past(power_state[0]) |-> module_reset_n_oe)
        else $error("reset off");
    c_sleep: cover property ($rose(power_state[2]));
    c_request: cover property ($rose(shutdown_req_n_oe));
    c_off: cover property ($rose(power_state[0]));
endmodule // mcps_props
bind mcps_top mcps_props #(.SEQ_CYC(SEQ_CYC)) mcps_props_inst (.*);
`default_nettype wire

/* testbench/mcps_carrier.sv */
// Purpose: Carrier board power control model.
// Assumes: Same clock as the sequencer.
// Notes: slow delays the answer to a request by seven cycles.
`timescale 1ns/1ps
`default_nettype none
module mcps_carrier (
    input wire logic ref_clk, // Clock.
    input wire logic want_on, // Power wanted.
    input wire logic vdd_in_ok, // Rail good.
    input wire logic slow, // Late answer.
    input wire logic shutdown_req_n_oe, // Request pull.
    input wire logic module_reset_n_oe, // Reset pull.
    output logic power_en = 1'b0, // Power-on pin.
    output logic reset_wire, // Reset line.
    output logic supply_on // Rails on.
);
    logic [7:0] req_q = 8'h00;
    logic shut_q = 1'b0;
    // The carrier never pulls reset, so the pull-up wins when the device lets go.
    // Only the power-on pin is driven; no other interface pin rises while reset is held.
    assign reset_wire = !module_reset_n_oe;
    assign supply_on = reset_wire;
    always @(posedge ref_clk) begin
        req_q <= {req_q[6:0], shutdown_req_n_oe};
        if (slow ? req_q[7] : req_q[0])
            shut_q <= 1'b1;
        else if (!want_on)
            shut_q <= 1'b0;
        // Latched so that a request dropped at off cannot power the module back up.
        power_en <= want_on && vdd_in_ok && !shut_q;
    end
endmodule // mcps_carrier
`default_nettype wire

/* testbench/tb.sv */
// Purpose: Self-checking bench for mcps_top.
// Assumes: Carrier model drives the power-on pin.
// Notes: SEQ_CYC stays at its default of 16.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
    $display("mismatch at %0t got %h exp %h", $time, a, b); end end
module tb;
    logic ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, want_on = 1'b0, slow = 1'b0;
    logic vdd_in_ok = 1'b0, temp_unsafe = 1'b0, temp_limit = 1'b0, undervoltage = 1'b0, usb_vbus = 1'b0;
    logic [3:0] avs_address = 4'h0, wake_pins = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd_q;
    logic [2:0] power_state;
    logic avs_waitrequest, power_en, reset_wire, mrst_oe, req_oe, sleep_n, strap_oe, supply_on;
    logic mrst_o, req_o, strap_o;
    int fails = 0, checks = 0;
    mcps_top mcps_top_inst (.*, .avs_byteenable(4'hf), .module_reset_n_in(reset_wire), .module_reset_n_out(mrst_o),
        .module_reset_n_oe(mrst_oe), .shutdown_req_n_out(req_o), .shutdown_req_n_oe(req_oe),
        .module_sleep_indicator_n(sleep_n), .supply_range_strap_out(strap_o), .supply_range_strap_oe(strap_oe));
    mcps_carrier mcps_carrier_inst (.*, .shutdown_req_n_oe(req_oe), .module_reset_n_oe(mrst_oe));
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0 && ++n < 99);
        // A slave that never answers counts as a mismatch.
        if (n >= 99)
            fails++;
        rd_q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic ws(input logic [2:0] s);
        int n = 0;
        while (power_state !== s && n++ < 2000)
            @(posedge ref_clk);
        `CHK(power_state, s)
    endtask
    task automatic up;
        want_on <= 1'b0;
        tick(4);
        want_on <= 1'b1;
        ws(3'h2);
        tick(24);
        `CHK(mrst_oe, 1'b0)
        `CHK(supply_on, 1'b1)
    endtask
    task automatic t_reset;
        `CHK(power_state, 3'h1)
        `CHK(mrst_oe, 1'b1)
        `CHK(req_oe, 1'b0)
        `CHK(sleep_n, 1'b1)
        `CHK(strap_oe, 1'b0)
        `CHK(strap_o, 1'b0)
        `CHK(mrst_o, 1'b0)
        `CHK(req_o, 1'b0)
        vdd_in_ok <= 1'b1;
        up;
        bus(1'b0, 4'hc, 32'h0);
        `CHK(rd_q, 32'h0)
        bus(1'b0, 4'h8, 32'h0);
        `CHK(rd_q[2:0], 3'h2)
        $display("reset test done");
    endtask
    task automatic t_glitch;
        want_on <= 1'b0;
        tick(100);
        want_on <= 1'b1;
        tick(300);
        `CHK(power_state, 3'h2)
        $display("glitch test done");
    endtask
    task automatic t_sleep;
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, 4'h4, 32'h0000_0101);
            bus(1'b1, 4'h0, 32'h0000_0006);
            ws(3'h4);
            tick(2);
            `CHK(sleep_n, 1'b0)
            `CHK(mrst_oe, 1'b0)
            bus(1'b1, 4'h0, 32'h0000_0004);
            `CHK(power_state, 3'h4)
            {temp_limit, wake_pins[0], usb_vbus} <= 3'h1 << i;
            ws(3'h2);
            {temp_limit, wake_pins[0], usb_vbus} <= 3'h0;
            tick(2);
            `CHK(sleep_n, 1'b1)
        end
        $display("sleep test done");
    endtask
    task automatic t_sw;
        slow <= 1'b1;
        bus(1'b1, 4'h0, 32'h0000_0001);
        tick(4);
        `CHK(req_oe, 1'b0)
        bus(1'b1, 4'h0, 32'h0000_0005);
        tick(2);
        `CHK(req_oe, 1'b1)
        `CHK(power_state, 3'h2)
        ws(3'h1);
        tick(2);
        `CHK(mrst_oe, 1'b1)
        slow <= 1'b0;
        $display("software test done");
    endtask
    task automatic t_events;
        for (int i = 0; i < 2; i++) begin
            up;
            {temp_unsafe, undervoltage} <= 2'h1 << i;
            tick(2);
            `CHK(req_oe, 1'b1)
            ws(3'h1);
            {temp_unsafe, undervoltage} <= 2'h0;
        end
        $display("event test done");
    endtask
    task automatic stop_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        tick(20);
        rst <= 1'b0;
        tick(1);
        t_reset;
        t_glitch;
        t_sleep;
        t_sw;
        t_events;
        stop_test;
    end
    initial begin
        tick(20000);
        fails++;
        stop_test;
    end
endmodule // tb
`default_nettype wire
